// *** hw/pss_unit.v ***
`timescale 1ns/100ps
`default_nettype none
`include "pss_map.vh"

// Summary of operation
// - Status visible at 03h and 83h
// - Flag-setting ops override written Z/DC/C
// - Timeout and powerdown flags ignore writes
// - Clear op zeroes top bits, sets Z
// - Bit 7 selects indirect bank pair
// - Bits 6-5 select direct bank
// - Timeout set by watchdog clear or sleep
// - Powerdown set by wdt clear, cleared sleep
// - Zero flag follows result zero
// - Digit carry from low nibble
// - Carry from result top bit
// - 13-bit PC, upper bits via latch
// - Any reset clears PC
// - Low byte write loads upper from latch
// - Call/goto use latch bits 4:3
// - Paging bits 4:3 select the call/goto page
// - Eight 13-bit entries, hidden pointer
// - Push call/irq, pop returns, latch untouched
// - Stack wraps circularly
// - No overflow or underflow flag
module pss_unit (
   // Clock and reset
   input  wire        clk,
   input  wire        nrst,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   // Flag update from ALU
   input  wire        flag_z_en,
   input  wire        flag_dc_en,
   input  wire        flag_c_en,
   input  wire        alu_z,
   input  wire        alu_dc,
   input  wire        alu_c,
   input  wire        register_clear_op,
   // Power and watchdog events
   input  wire        watchdog_clear_op,
   input  wire        sleep_op,
   input  wire        watchdog_timeout,
   // Program flow
   input  wire        pc_advance,
   input  wire        jump_op,
   input  wire [10:0] jump_target,
   input  wire        call_op,
   input  wire        irq_vector,
   input  wire [12:0] irq_addr,
   input  wire        return_op,
   // Outputs
   output wire [12:0] pc,
   output wire [7:0]  core_status,
   output wire        indirect_bank_select,
   output wire [1:0]  direct_bank_select
);

   reg  [7:0]  status_q;
   reg  [7:0]  status_d;
   reg  [12:0] pc_q;
   reg  [12:0] pc_d;
   reg  [4:0]  pc_latch_q;
   reg  [2:0]  sp_q;
   reg  [2:0]  sp_d;
   reg  [12:0] stack_q [0:7];
   wire        hit_status;
   wire        hit_pc_low;
   wire        hit_pc_latch;
   wire        push;
   wire        pop;
   wire [12:0] pc_inc;
   wire [2:0]  sp_top;

   assign hit_status = (reg_addr == `PSS_STATUS_ADDR_B0) || (reg_addr == `PSS_STATUS_ADDR_B1);
   assign hit_pc_low   = (reg_addr == `PSS_PC_LOW_ADDR_B0) || (reg_addr == `PSS_PC_LOW_ADDR_B1);
   assign hit_pc_latch = (reg_addr == `PSS_PC_LATCH_ADDR_B0) || (reg_addr == `PSS_PC_LATCH_ADDR_B1);
   assign push       = call_op | irq_vector;
   assign pop        = return_op;
   assign pc_inc     = pc_q + 13'h0001;
   assign sp_top     = sp_q - 3'h1;

   assign pc                   = pc_q;
   assign core_status          = status_q;
   assign indirect_bank_select = status_q[`PSS_IND_BANK_BIT];
   assign direct_bank_select   = status_q[`PSS_DIR_BANK_HI:`PSS_DIR_BANK_LO];

   // Status next value
   always @* begin
      status_d = status_q;
      if (reg_wr && hit_status) begin
         // Bits 4:3 are never taken from the bus
         status_d[7:5] = reg_wdata[7:5];
         if (!flag_z_en)
            status_d[`PSS_ZERO_BIT] = reg_wdata[`PSS_ZERO_BIT];
         if (!flag_dc_en)
            status_d[`PSS_DIGIT_BIT] = reg_wdata[`PSS_DIGIT_BIT];
         if (!flag_c_en)
            status_d[`PSS_CARRY_BIT] = reg_wdata[`PSS_CARRY_BIT];
      end
      if (register_clear_op && hit_status) begin
         status_d[7:5] = 3'h0;
         status_d[`PSS_ZERO_BIT] = 1'b1;
      end else begin
         if (flag_z_en)
            status_d[`PSS_ZERO_BIT] = alu_z;
         if (flag_dc_en)
            status_d[`PSS_DIGIT_BIT] = alu_dc;
         if (flag_c_en)
            status_d[`PSS_CARRY_BIT] = alu_c;
      end
      // Timeout and powerdown change only on hardware events
      if (watchdog_clear_op) begin
         status_d[`PSS_TIMEOUT_BIT] = 1'b1;
         status_d[`PSS_PWRDN_BIT] = 1'b1;
      end else if (sleep_op) begin
         status_d[`PSS_TIMEOUT_BIT] = 1'b1;
         status_d[`PSS_PWRDN_BIT] = 1'b0;
      end
      if (watchdog_timeout)
         status_d[`PSS_TIMEOUT_BIT] = 1'b0;
   end

   // Program counter next value
   always @* begin
      pc_d = pc_q;
      if (pop)
         pc_d = stack_q[sp_top];
      else if (irq_vector)
         pc_d = irq_addr;
      else if (call_op || jump_op)
         pc_d = {pc_latch_q[4:3], jump_target};
      else if (reg_wr && hit_pc_low)
         pc_d = {pc_latch_q, reg_wdata};
      else if (pc_advance)
         pc_d = pc_inc;
   end

   always @* begin
      sp_d = sp_q;
      if (push)
         sp_d = sp_q + 3'h1;
      else if (pop)
         sp_d = sp_top;
   end

   always @(posedge clk) begin
      if (!nrst) begin
         status_q <= `PSS_STATUS_RST;
         pc_q     <= `PSS_PC_RST;
         pc_latch_q <= `PSS_PC_LATCH_RST;
         sp_q     <= 3'h0;
      end else begin
         status_q <= status_d;
         pc_q     <= pc_d;
         sp_q     <= sp_d;
         if (reg_wr && hit_pc_latch)
            pc_latch_q <= reg_wdata[4:0];
      end
   end

   // Stack entries; return address is PC+1 for call, the current PC for irq
   genvar gi;
   generate
      for (gi = 0; gi < `PSS_STACK_DEPTH; gi = gi + 1) begin : g_stack
         always @(posedge clk) begin
            if (!nrst)
               stack_q[gi] <= 13'h0000;
            else if (push && (sp_q == gi))
               stack_q[gi] <= call_op ? pc_inc : pc_q;
         end
      end
   endgenerate

   // Read data, one cycle after the strobe
   always @(posedge clk) begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         if (hit_status)
            reg_rdata <= status_q;
         else if (hit_pc_low)
            reg_rdata <= pc_q[7:0];
         else if (hit_pc_latch)
            reg_rdata <= {3'h0, pc_latch_q};
         else
            reg_rdata <= 8'h00;
      end else
         reg_rdata <= 8'h00;
   end

endmodule // pss_unit
`default_nettype wire

// *** shared/pss_map.vh ***
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
// Register offsets seen on the data bus
`define PSS_STATUS_ADDR_B0   8'h03
`define PSS_STATUS_ADDR_B1   8'h83
`define PSS_PC_LOW_ADDR_B0   8'h02
`define PSS_PC_LOW_ADDR_B1   8'h82
`define PSS_PC_LATCH_ADDR_B0 8'h0a
`define PSS_PC_LATCH_ADDR_B1 8'h8a
// Status field positions
`define PSS_IND_BANK_BIT     7
`define PSS_DIR_BANK_HI      6
`define PSS_DIR_BANK_LO      5
`define PSS_TIMEOUT_BIT      4
`define PSS_PWRDN_BIT        3
`define PSS_ZERO_BIT         2
`define PSS_DIGIT_BIT        1
`define PSS_CARRY_BIT        0
// Reset values
`define PSS_STATUS_RST       8'h18
`define PSS_PC_RST           13'h0000
`define PSS_PC_LATCH_RST     5'h00
// Sizes
`define PSS_PC_W             13
`define PSS_STACK_DEPTH      8
`define PSS_SP_W             3
`endif

// *** test/pss_alu.sv ***
`timescale 1ns/100ps
`default_nettype none
module pss_alu (
   // Operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   // Flags
   output logic z,
   output logic dc,
   output logic c
);
   wire [8:0] s = a + b;
   assign z = s[7:0] == 8'h00;
   assign dc = a[3:0] + b[3:0] > 5'h0f;
   assign c = s[8];
endmodule // pss_alu
`default_nettype wire

// *** test/pss_unit_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module pss_chk (
   // Clock, reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Events
   input wire logic flag_z_en,
   input wire logic alu_z,
   input wire logic register_clear_op,
   input wire logic watchdog_clear_op,
   input wire logic sleep_op,
   input wire logic watchdog_timeout,
   // State
   input wire logic [12:0] pc,
   input wire logic [7:0] core_status
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire hit = reg_addr[6:0] == 7'h03;
   wire ev = sleep_op || watchdog_clear_op || watchdog_timeout;
   rst_vals_a: assert property ($rose(nrst) |-> pc == 13'h0 && core_status == 8'h18)
      else $error("reset");
   rd_status_a: assert property (reg_rd && hit |=> reg_rdata == $past(core_status))
      else $error("read");
   z_wins_a: assert property (flag_z_en && !(register_clear_op && hit) |=> core_status[2] == $past(alu_z))
      else $error("z");
   sleep_flags_a: assert property (sleep_op && !watchdog_clear_op && !watchdog_timeout |=> core_status[4:3] == 2'b10)
      else $error("sleep");
   timeout_clears_a: assert property (watchdog_timeout |=> !core_status[4])
      else $error("timeout");
   dog_clear_a: assert property (watchdog_clear_op && !watchdog_timeout |=> core_status[4:3] == 2'b11)
      else $error("watchdog clear");
   clear_op_a: assert property (register_clear_op && hit |=> core_status[7:5] == 3'h0 && core_status[2])
      else $error("clear");
   flags_ro_a: assert property (!ev |=> $stable(core_status[4:3]))
      else $error("hardware flags");
endmodule // pss_chk
`default_nettype wire

// *** test/pss_unit_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s %h %h", n, e, g); end end
module pss_unit_tb;
   logic clk = 0, nrst = 0;
   logic [13:0] ev = 0;
   logic [7:0] ra = 0, wd = 0, x = 0, y = 0, es, d;
   logic [12:0] jt = 0, ep, stk [0:8];
   wire [7:0] rdata, st;
   wire [12:0] pc;
   wire az, adc, ac, ibs;
   wire [1:0] dbs;
   integer seed = 94991, fail_count = 0, n_checks = 0, i;
   pss_alu u_alu (.a(x), .b(y), .z(az), .dc(adc), .c(ac));
   pss_unit u_dut (.clk(clk), .nrst(nrst), .reg_addr(ra), .reg_wdata(wd), .reg_wr(ev[0]), .reg_rd(ev[1]),
      .reg_rdata(rdata), .flag_z_en(ev[11]), .flag_dc_en(ev[12]), .flag_c_en(ev[13]), .alu_z(az), .alu_dc(adc),
      .alu_c(ac), .register_clear_op(ev[2]), .watchdog_clear_op(ev[3]), .sleep_op(ev[4]), .watchdog_timeout(ev[5]),
      .pc_advance(ev[6]), .jump_op(ev[7]), .jump_target(jt[10:0]), .call_op(ev[8]), .irq_vector(ev[9]),
      .irq_addr(jt), .return_op(ev[10]), .pc(pc), .core_status(st), .indirect_bank_select(ibs),
      .direct_bank_select(dbs));
   task go(input [13:0] e, input [7:0] a, w, input [12:0] t);
      @(posedge clk);
      ev <= e;
      ra <= a;
      wd <= w;
      jt <= t;
      @(posedge clk);
      ev <= 14'h0;
      @(negedge clk);
   endtask
   task rd(input [7:0] a, e);
      go(14'h2, a, 8'h00, 13'h0);
      `CK("rdata", e, rdata)
   endtask
   task evc(input [13:0] e, input [1:0] f);
      go(e, 8'h00, 8'h00, 13'h0);
      es[4:3] = f;
      `CK("hw_flags", es, st)
   endtask
   task wrap_up;
      $display("checks %0d fails %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial forever #20 clk = ~clk;
   initial begin
      #40000;
      fail_count++;
      wrap_up;
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1;
      es = 8'h18;
      rd(8'h03, es);
      rd(8'h40, 8'h00);
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         go(14'h1, i[0] ? 8'h83 : 8'h03, d, 13'h0);
         es = {d[7:5], es[4:3], d[2:0]};
         rd(i[0] ? 8'h03 : 8'h83, es);
         `CK("bank", es[7:5], {ibs, dbs})
      end
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         {x, y} <= i ? $random(seed) : 16'hff01;
         d = $random(seed);
         go(14'h3801, 8'h03, d, 13'h0);
         es = {d[7:5], es[4:3], az, adc, ac};
         `CK("flags", es, st)
      end
      go(14'h3804, 8'h83, 8'hff, 13'h0);
      es = {3'h0, es[4:3], 1'b1, es[1:0]};
      `CK("clear", es, st)
      evc(14'h10, 2'b10);
      evc(14'h20, 2'b00);
      evc(14'h08, 2'b11);
      evc(14'h30, 2'b00);
      evc(14'h18, 2'b11);
      $display("status done");
      go(14'h1, 8'h0a, 8'hfd, 13'h0);
      d = $random(seed);
      go(14'h1, 8'h82, d, 13'h0);
      ep = {5'h1d, d};
      `CK("pc_low", ep, pc)
      go(14'h40, 8'h00, 8'h00, 13'h0);
      ep = ep + 13'h1;
      `CK("adv", ep, pc)
      ep = {2'b11, 11'h2a5};
      go(14'h80, 8'h00, 8'h00, ep);
      `CK("goto", ep, pc)
      for (i = 0; i < 9; i++) begin
         stk[i] = ep + (i < 8);
         ep = {2'b11, 11'($random(seed))};
         go(i < 8 ? 14'h100 : 14'h200, 8'h00, 8'h00, ep);
         `CK("pc", ep, pc)
      end
      for (i = 8; i > 0; i--) begin
         go(14'h400, 8'h00, 8'h00, 13'h0);
         `CK("pop", stk[i], pc)
      end
      go(14'h1, 8'h02, d, 13'h0);
      `CK("latch", {5'h1d, d}, pc)
      $display("pc done");
      @(posedge clk);
      nrst <= 0;
      @(posedge clk);
      nrst <= 1;
      @(negedge clk);
      `CK("rst", 13'h0, pc)
      wrap_up;
   end
endmodule // pss_unit_tb
bind pss_unit pss_chk u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .flag_z_en(flag_z_en), .alu_z(alu_z), .register_clear_op(register_clear_op),
   .watchdog_clear_op(watchdog_clear_op), .sleep_op(sleep_op), .watchdog_timeout(watchdog_timeout), .pc(pc),
   .core_status(core_status));
`default_nettype wire
